// ==== design/ffc_pkg.sv ====
// shared formats, codes and constants of the floating-point format converter
package ffc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // field widths
  localparam int SH_EXP_W = 4;
  localparam int SH_FRAC_W = 11;
  localparam int EXP_W = 8;
  localparam int SG_FRAC_W = 23;
  localparam int EX_FRAC_W = 31;
  localparam int WORD_W = 40;

  // zero padding below a widened mantissa
  localparam int SH_PAD_SG = 12;
  localparam int SH_PAD_EX = 20;
  localparam int SG_PAD_EX = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reserved and saturation encodings
  localparam logic [SH_EXP_W-1:0] SH_ZERO_EXP = 4'h8;
  localparam logic [EXP_W-1:0] ZERO_EXP = 8'h80;
  localparam logic [EXP_W-1:0] MAX_EXP = 8'h7f;
  localparam logic [SG_FRAC_W-1:0] POS_SAT_FRAC = 23'h7fffff;
  localparam logic [SG_FRAC_W-1:0] NEG_SAT_FRAC = 23'h000000;

  // ieee single fields
  localparam logic [EXP_W-1:0] IE_EXP_MAX = 8'hff;
  localparam logic [EXP_W-1:0] IE_EXP_MIN = 8'h00;
  localparam logic [EXP_W-1:0] IE_BIAS = 8'h7f;
  localparam logic [EXP_W-1:0] IE_BIAS_NEG = 8'h80;
  localparam logic [SG_FRAC_W-1:0] IE_FRAC_ONE = 23'h000001;

  // result word after reset: single zero in the low 32 bits
  localparam logic [WORD_W-1:0] RESET_WORD = 40'h0080000000;

  ////////////////////////////////////////////////////////////////////////////
  // conversion select
  typedef enum logic [2:0] {
    FFC_SH2SG,
    FFC_SH2EX,
    FFC_SG2EX,
    FFC_EX2SG,
    FFC_IE2SG
  } ffc_op_t;

  // word layouts
  typedef struct packed {
    logic [SH_EXP_W-1:0] exp;
    logic sign;
    logic [SH_FRAC_W-1:0] frac;
  } ffc_sh_t;

  typedef struct packed {
    logic [EXP_W-1:0] exp;
    logic sign;
    logic [SG_FRAC_W-1:0] frac;
  } ffc_sg_t;

  typedef struct packed {
    logic [EXP_W-1:0] exp;
    logic sign;
    logic [EX_FRAC_W-1:0] frac;
  } ffc_ex_t;

  // request and answer carriers
  typedef struct packed {
    logic valid;
    ffc_op_t op;
    logic [WORD_W-1:0] operand;
  } ffc_req_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
    logic ovf;
    logic nan;
    logic inf;
    logic denorm;
    logic bad_op;
  } ffc_res_t;

endpackage : ffc_pkg

// ==== design/ffc_converter.sv ====
// floating-point format converter: widening, narrowing and ieee single mapping
//
// Summary of operation
// [RQ1] conversion is part of the datapath; no extra cycle beyond one register
// [RQ2] a zero widened to more precision becomes the reserved zero of that format
// [RQ3] short to single: sign-extend exponent, mantissa on top, 12 low bits zero
// [RQ4] short to extended: sign-extend exponent, mantissa on top, 20 low bits zero
// [RQ5] single to extended: exponent kept, eight zero bits appended below mantissa
// [RQ6] extended to single: exponent kept, eight low mantissa bits dropped, no rounding
// [RQ7] ieee input: sign on top, 8-bit exponent biased by 127, 23-bit fraction
// [RQ8] ieee exponent 255 is nan or infinity, 0 is zero or denormal, else normal
// [RQ9] signed exponent -128 is zero, otherwise sign, inverted sign and fraction
// [RQ10] ieee maximum exponent, positive: exponent 7fh, sign 0, fraction 7fffffh
// [RQ11] ieee maximum exponent, negative: exponent 7fh, sign 1, fraction 000000h
// [RQ12] each saturated nan or infinity raises overflow together with the result
// [RQ13] positive normal ieee: exponent minus 7fh, sign 0, fraction copied
// [RQ14] negative normal, nonzero fraction: exponent minus 7fh, sign 1, inverse plus one
// [RQ15] negative normal, zero fraction: exponent minus 80h, sign 1, fraction zero
// [RQ16] ieee zero exponent of either sign gives exponent 80h, sign 0, fraction 0
// [RQ17] single format: 8-bit exponent over sign bit and 23-bit fraction
// [RQ18] extended format: 8-bit exponent over sign bit and 31-bit fraction
// [RQ19] operand arrives with a select code; word and overflow answer one cycle later
// [RQ20] reset clears the result to the 2s-complement zero and drops overflow
`timescale 1ns/1ps

module ffc_converter
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // conversion request
  input wire ffc_pkg::ffc_req_t req,
  // conversion answer
  output ffc_pkg::ffc_res_t res
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // reserved zero exponent of single and extended words
  function automatic logic exp_is_zero(input logic [ffc_pkg::EXP_W-1:0] exp);
    exp_is_zero = (exp == ffc_pkg::ZERO_EXP);
  endfunction : exp_is_zero

  // reserved zero of the single format
  function automatic ffc_pkg::ffc_sg_t sg_zero();
    ffc_pkg::ffc_sg_t z;
    z.exp = ffc_pkg::ZERO_EXP;
    z.sign = 1'b0;
    z.frac = '0;
    sg_zero = z;
  endfunction : sg_zero

  // reserved zero of the extended format
  function automatic ffc_pkg::ffc_ex_t ex_zero();
    ffc_pkg::ffc_ex_t z;
    z.exp = ffc_pkg::ZERO_EXP;
    z.sign = 1'b0;
    z.frac = '0;
    ex_zero = z;
  endfunction : ex_zero

  // single word placed in the low bits of the answer word
  function automatic logic [ffc_pkg::WORD_W-1:0] sg_word(input ffc_pkg::ffc_sg_t v);
    sg_word = {8'h00, v};
  endfunction : sg_word

  ////////////////////////////////////////////////////////////////////////////
  // source views of the operand

  ffc_pkg::ffc_sh_t src_sh;
  ffc_pkg::ffc_sg_t src_sg;
  ffc_pkg::ffc_ex_t src_ex;

  assign src_sh = req.operand[15:0];
  assign src_sg = req.operand[31:0]; // RQ17
  assign src_ex = req.operand; // RQ18

  ////////////////////////////////////////////////////////////////////////////
  // short source

  wire logic sh_is_zero;
  wire logic [ffc_pkg::EXP_W-1:0] sh_exp_ext;
  wire logic [ffc_pkg::SH_FRAC_W:0] sh_mant;

  assign sh_is_zero = (src_sh.exp == ffc_pkg::SH_ZERO_EXP); // RQ9
  assign sh_exp_ext = {{4{src_sh.exp[3]}}, src_sh.exp};
  assign sh_mant = {src_sh.sign, src_sh.frac};

  // short to single
  ffc_pkg::ffc_sg_t sh2sg_raw;
  ffc_pkg::ffc_sg_t sh2sg;

  assign sh2sg_raw = {sh_exp_ext, sh_mant, {ffc_pkg::SH_PAD_SG{1'b0}}}; // RQ3
  assign sh2sg = sh_is_zero ? sg_zero() : sh2sg_raw; // RQ2

  // short to extended
  ffc_pkg::ffc_ex_t sh2ex_raw;
  ffc_pkg::ffc_ex_t sh2ex;

  assign sh2ex_raw = {sh_exp_ext, sh_mant, {ffc_pkg::SH_PAD_EX{1'b0}}}; // RQ4
  assign sh2ex = sh_is_zero ? ex_zero() : sh2ex_raw; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // single source

  wire logic sg_is_zero;
  ffc_pkg::ffc_ex_t sg2ex_raw;
  ffc_pkg::ffc_ex_t sg2ex;

  assign sg_is_zero = exp_is_zero(src_sg.exp); // RQ9
  assign sg2ex_raw = {src_sg, {ffc_pkg::SG_PAD_EX{1'b0}}}; // RQ5
  assign sg2ex = sg_is_zero ? ex_zero() : sg2ex_raw; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // extended source

  wire logic ex_is_zero;
  ffc_pkg::ffc_sg_t ex2sg_raw;
  ffc_pkg::ffc_sg_t ex2sg;

  assign ex_is_zero = exp_is_zero(src_ex.exp); // RQ9
  assign ex2sg_raw = src_ex[ffc_pkg::WORD_W-1:ffc_pkg::SG_PAD_EX]; // RQ6
  // a zero stays the clean reserved zero after truncation
  assign ex2sg = ex_is_zero ? sg_zero() : ex2sg_raw;

  ////////////////////////////////////////////////////////////////////////////
  // ieee single source

  wire logic ie_sign;
  wire logic [ffc_pkg::EXP_W-1:0] ie_exp;
  wire logic [ffc_pkg::SG_FRAC_W-1:0] ie_frac;

  assign ie_sign = req.operand[31]; // RQ7
  assign ie_exp = req.operand[30:23]; // RQ7
  assign ie_frac = req.operand[22:0]; // RQ7

  // classification on the unsigned exponent
  wire logic ie_exp_max;
  wire logic ie_exp_min;
  wire logic ie_frac_zero;
  wire logic ie_nan;
  wire logic ie_inf;
  wire logic ie_denorm;
  wire logic ie_normal;

  assign ie_exp_max = (ie_exp == ffc_pkg::IE_EXP_MAX); // RQ8
  assign ie_exp_min = (ie_exp == ffc_pkg::IE_EXP_MIN); // RQ8
  assign ie_frac_zero = (ie_frac == '0);
  assign ie_nan = ie_exp_max && !ie_frac_zero; // RQ8
  assign ie_inf = ie_exp_max && ie_frac_zero; // RQ8
  assign ie_denorm = ie_exp_min && !ie_frac_zero; // RQ8
  assign ie_normal = !ie_exp_max && !ie_exp_min; // RQ8

  // saturation values
  ffc_pkg::ffc_sg_t ie_pos_sat;
  ffc_pkg::ffc_sg_t ie_neg_sat;

  assign ie_pos_sat = {ffc_pkg::MAX_EXP, 1'b0, ffc_pkg::POS_SAT_FRAC}; // RQ10
  assign ie_neg_sat = {ffc_pkg::MAX_EXP, 1'b1, ffc_pkg::NEG_SAT_FRAC}; // RQ11

  // normalized values
  wire logic [ffc_pkg::EXP_W-1:0] ie_exp_unb;
  wire logic [ffc_pkg::EXP_W-1:0] ie_exp_unb_neg;
  wire logic [ffc_pkg::SG_FRAC_W-1:0] ie_frac_neg;
  ffc_pkg::ffc_sg_t ie_pos_norm;
  ffc_pkg::ffc_sg_t ie_neg_norm;
  ffc_pkg::ffc_sg_t ie_neg_pow2;

  assign ie_exp_unb = ie_exp - ffc_pkg::IE_BIAS; // RQ13
  assign ie_exp_unb_neg = ie_exp - ffc_pkg::IE_BIAS_NEG; // RQ15
  assign ie_frac_neg = (~ie_frac) + ffc_pkg::IE_FRAC_ONE; // RQ14
  assign ie_pos_norm = {ie_exp_unb, 1'b0, ie_frac}; // RQ13
  assign ie_neg_norm = {ie_exp_unb, 1'b1, ie_frac_neg}; // RQ14
  assign ie_neg_pow2 = {ie_exp_unb_neg, 1'b1, ffc_pkg::NEG_SAT_FRAC}; // RQ15

  // case selection, saturation first, then zero, then normal
  ffc_pkg::ffc_sg_t ie_sat;
  ffc_pkg::ffc_sg_t ie_norm;
  ffc_pkg::ffc_sg_t ie2sg;
  wire logic ie_ovf;

  assign ie_sat = ie_sign ? ie_neg_sat : ie_pos_sat; // RQ10 RQ11
  assign ie_norm = !ie_sign ? ie_pos_norm : (ie_frac_zero ? ie_neg_pow2 : ie_neg_norm);
  assign ie2sg = ie_exp_max ? ie_sat : (ie_exp_min ? sg_zero() : ie_norm); // RQ16
  assign ie_ovf = ie_exp_max; // RQ12

  ////////////////////////////////////////////////////////////////////////////
  // result selection by conversion code

  logic [ffc_pkg::WORD_W-1:0] sel_word;
  logic sel_ovf;
  logic sel_nan;
  logic sel_inf;
  logic sel_denorm;
  logic sel_bad;

  always_comb
  begin
    sel_word = ffc_pkg::RESET_WORD;
    sel_ovf = 1'b0;
    sel_nan = 1'b0;
    sel_inf = 1'b0;
    sel_denorm = 1'b0;
    sel_bad = 1'b0;
    unique case (req.op)
      ffc_pkg::FFC_SH2SG:
      begin
        sel_word = sg_word(sh2sg);
      end
      ffc_pkg::FFC_SH2EX:
      begin
        sel_word = sh2ex;
      end
      ffc_pkg::FFC_SG2EX:
      begin
        sel_word = sg2ex;
      end
      ffc_pkg::FFC_EX2SG:
      begin
        sel_word = sg_word(ex2sg);
      end
      ffc_pkg::FFC_IE2SG:
      begin
        sel_word = sg_word(ie2sg);
        sel_ovf = ie_ovf; // RQ12
        sel_nan = ie_nan;
        sel_inf = ie_inf;
        sel_denorm = ie_denorm;
      end
      default:
      begin
        // unused select codes answer zero and flag the code
        sel_bad = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer register

  ffc_pkg::ffc_res_t res_reg;
  ffc_pkg::ffc_res_t res_next;

  // a word is only loaded when a request is presented
  always_comb
  begin
    res_next = res_reg;
    res_next.valid = req.valid;
    if (req.valid)
    begin
      res_next.word = sel_word;
      res_next.ovf = sel_ovf;
      res_next.nan = sel_nan;
      res_next.inf = sel_inf;
      res_next.denorm = sel_denorm;
      res_next.bad_op = sel_bad;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      res_reg.valid <= 1'b0;
      res_reg.word <= ffc_pkg::RESET_WORD; // RQ20
      res_reg.ovf <= 1'b0; // RQ20
      res_reg.nan <= 1'b0;
      res_reg.inf <= 1'b0;
      res_reg.denorm <= 1'b0;
      res_reg.bad_op <= 1'b0;
    end
    else if (clk_en)
    begin
      res_reg <= res_next; // RQ1 RQ19
    end
  end

  assign res = res_reg;

endmodule : ffc_converter

// ==== testbench/ffc_converter_sva.sv ====
// port assertions of the format converter
`timescale 1ns/1ps

module ffc_converter_chk
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // request and answer
  input wire ffc_pkg::ffc_req_t req,
  input wire ffc_pkg::ffc_res_t res
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  wire tk = clk_en && req.valid;
  wire ie = tk && req.op == ffc_pkg::FFC_IE2SG;
  wire [7:0] iex = req.operand[30:23];
  wire sat = ie && iex == 8'hff;
  wire pnrm = ie && iex != 8'hff && iex != 8'h00 && !req.operand[31];

  a_answer_next: assert property (tk |=> res.valid)
    else $error("answer missing");
  a_no_spurious: assert property (clk_en && !req.valid |=> !res.valid)
    else $error("answer without request");
  a_hold_frozen: assert property (!clk_en |=> $stable(res))
    else $error("result moved while disabled");
  a_pos_sat: assert property (sat && !req.operand[31] |=> res.word == 40'h007f7fffff && res.ovf)
    else $error("positive saturation wrong");
  a_neg_sat: assert property (sat && req.operand[31] |=> res.word == 40'h007f800000 && res.ovf)
    else $error("negative saturation wrong");
  a_ieee_zero: assert property (ie && iex == 8'h00 |=> res.word == 40'h0080000000 && !res.ovf)
    else $error("ieee zero wrong");
  a_pos_norm: assert property (pnrm |=> !res.ovf && res.word ==
    {8'h00, $past(iex) - 8'h7f, 1'b0, $past(req.operand[22:0])}) else $error("positive normal wrong");
  a_sg_widen: assert property (tk && req.op == ffc_pkg::FFC_SG2EX && req.operand[31:24] != 8'h80
    |=> res.word == {$past(req.operand[31:0]), 8'h00}) else $error("single widening wrong");
  a_ex_trunc: assert property (tk && req.op == ffc_pkg::FFC_EX2SG && req.operand[39:32] != 8'h80
    |=> res.word == {8'h00, $past(req.operand[39:8])}) else $error("extended narrowing wrong");

  c_sat: cover property (sat);
  c_b2b: cover property (tk ##1 tk);
  c_frozen: cover property (!clk_en && req.valid);
endmodule : ffc_converter_chk

// ==== testbench/ffc_src.sv ====
// operand source standing for the requesting datapath
`timescale 1ns/1ps

module ffc_src
(
  // clock
  input wire logic core_clk,
  // request out
  output ffc_pkg::ffc_req_t req
);
  initial req = '0;

  // op and operand go out together, held until the next call
  task send(input ffc_pkg::ffc_op_t op, input logic [39:0] x);
    @(posedge core_clk);
    req <= '{1'b1, op, x};
  endtask : send

  task idle();
    @(posedge core_clk);
    req.valid <= 1'b0;
  endtask : idle
endmodule : ffc_src

// ==== testbench/ffc_converter_bench.sv ====
// self-checking bench of the format converter
`timescale 1ns/1ps

module ffc_converter_bench;
  logic core_clk;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  ffc_pkg::ffc_req_t req;
  ffc_pkg::ffc_res_t res;
  int err_count = 0;
  int n_compared = 0;

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ffc_src src (.core_clk(core_clk), .req(req));
  ffc_converter dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .req(req), .res(res));

  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task test_done();
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task see(input logic v, input logic [39:0] w, input logic [4:0] f);
    chk("valid", {39'h0, v}, {39'h0, res.valid});
    chk("word", w, res.word);
    chk("flags", {35'h0, f}, {35'h0, res[4:0]});
  endtask : see

  // one request, answer looked at after the taking edge
  task conv(input ffc_pkg::ffc_op_t op, input logic [39:0] x, w, input logic [4:0] f);
    src.send(op, x);
    src.idle();
    #1;
    see(1'b1, w, f);
  endtask : conv

  task t_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    see(1'b0, 40'h0080000000, 5'h00);
    nrst <= 1'b1;
  endtask : t_reset

  task t_widen();
    conv(ffc_pkg::FFC_SH2SG, 40'hcda5, {8'h00, 8'hfc, 1'b1, 11'h5a5, 12'h000}, 5'h00);
    conv(ffc_pkg::FFC_SH2EX, 40'h35a5, {8'h03, 1'b0, 11'h5a5, 20'h00000}, 5'h00);
    conv(ffc_pkg::FFC_SG2EX, 40'h01400001, 40'h0140000100, 5'h00);
    conv(ffc_pkg::FFC_SH2SG, 40'h8000, 40'h0080000000, 5'h00);
    conv(ffc_pkg::FFC_SH2EX, 40'h87ff, 40'h8000000000, 5'h00);
    conv(ffc_pkg::FFC_SG2EX, 40'h80123456, 40'h8000000000, 5'h00);
    conv(ffc_pkg::FFC_EX2SG, 40'h01400000ff, 40'h0001400000, 5'h00);
    conv(ffc_pkg::FFC_EX2SG, 40'hfe7fffffff, 40'h00fe7fffff, 5'h00);
    // unused select code answers the reset word with only the bad-code flag
    conv(ffc_pkg::ffc_op_t'(3'h5), 40'h01400000ff, 40'h0080000000, 5'h01);
    conv(ffc_pkg::FFC_SH2SG, 40'hcda5, {8'h00, 8'hfc, 1'b1, 11'h5a5, 12'h000}, 5'h00);
  endtask : t_widen

  task t_ieee();
    logic [31:0] xi [10] = '{32'h3f800000, 32'h40490fdb, 32'hc0490fdb, 32'hbf800000, 32'h00400000,
      32'h80000000, 32'h7fc00000, 32'hffc00001, 32'hff800000, 32'h7f800000};
    logic [31:0] wo [10] = '{32'h00000000, 32'h01490fdb, 32'h01b6f025, 32'hff800000, 32'h80000000,
      32'h80000000, 32'h7f7fffff, 32'h7f800000, 32'h7f800000, 32'h7f7fffff};
    logic [4:0] fl [10] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h00, 5'h18, 5'h18, 5'h14, 5'h14};
    for (int i = 0; i < 10; i++)
      conv(ffc_pkg::FFC_IE2SG, {8'h00, xi[i]}, {8'h00, wo[i]}, fl[i]);
  endtask : t_ieee

  task t_b2b();
    src.send(ffc_pkg::FFC_SG2EX, 40'h01400000);
    src.send(ffc_pkg::FFC_EX2SG, 40'h0140000012);
    #1;
    see(1'b1, 40'h0140000000, 5'h00);
    src.idle();
    #1;
    see(1'b1, 40'h0001400000, 5'h00);
    @(posedge core_clk);
    #1;
    see(1'b0, 40'h0001400000, 5'h00);
  endtask : t_b2b

  task t_freeze();
    src.send(ffc_pkg::FFC_IE2SG, 40'h40490fdb);
    src.send(ffc_pkg::FFC_IE2SG, 40'h3f800000);
    clk_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    see(1'b1, 40'h0001490fdb, 5'h00);
    @(posedge core_clk);
    clk_en <= 1'b1;
    src.idle();
    #1;
    see(1'b1, 40'h0000000000, 5'h00);
  endtask : t_freeze

  initial
  begin
    t_reset();
    t_widen();
    t_ieee();
    t_reset();
    t_b2b();
    t_freeze();
    test_done();
  end

  initial
  begin
    #100000;
    err_count++;
    test_done();
  end
endmodule : ffc_converter_bench

bind ffc_converter ffc_converter_chk u_chk (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .req(req), .res(res));
